//--- src/msr_defs.vh
`ifndef MSR_DEFS_VH
`define MSR_DEFS_VH
`define MSR_ADDR_RXBYTE 8'hE5
`define MSR_ADDR_STATUS 8'hE6
`define MSR_ADDR_PROG 8'hE8
`define MSR_ST_IRQ 15
`define MSR_ST_PF 13
`define MSR_ST_TXRDY 12
`define MSR_ST_TXUND 11
`define MSR_ST_ENERGY 10
`define MSR_ST_ALT 9
`define MSR_ST_ZEROS 8
`define MSR_ST_ONES 7
`define MSR_ST_RXRDY 6
`define MSR_ST_RXOVF 5
`define MSR_ST_FRAME 4
`define MSR_ST_PAR 3
`define MSR_MSK_PF 4
`define MSR_MSK_TX 3
`define MSR_MSK_EN 2
`define MSR_MSK_PAT 1
`define MSR_MSK_RX 0
`define MSR_CLK_HZ 10000000
`define MSR_PROG_US 150
`define MSR_PROG_CYC ((`MSR_PROG_US * (`MSR_CLK_HZ / 1000000)))
`define MSR_MODE_US 150
`define MSR_MODE_CYC ((`MSR_MODE_US * (`MSR_CLK_HZ / 1000000)))
`define MSR_HDR_TX 16'h8000
`define MSR_HDR_RX 16'h8001
`define MSR_MEM_DEPTH 27
`endif

//--- src/msr_rx_pack.v
`timescale 1ns/1ps
`include "msr_defs.vh"
// Aligns a received character so that the first bit sits at bit 0.
module msr_rx_pack (
   input wire i_sync,
   input wire [2:0] i_fmt,
   input wire [7:0] i_shift,
   output reg [7:0] o_byte
);
   reg [3:0] nbits;
   always @* begin
      nbits = 4'h8;
      o_byte = i_shift;
      if (!i_sync) begin
         nbits = 4'h5 + {2'b00, i_fmt[2:1]};
         if (nbits == 4'h5) begin
            o_byte = {3'h0, i_shift[7:3]};
         end else if (nbits == 4'h6) begin
            o_byte = {2'h0, i_shift[7:2]};
         end else if (nbits == 4'h7) begin
            o_byte = {1'b0, i_shift[7:1]};
         end
      end
   end
endmodule

//--- src/msr_prog_mem.v
`timescale 1ns/1ps
`include "msr_defs.vh"
// Tone parameter store, one word per programming write until all 27 words are filled.
module msr_prog_mem #(
   parameter DEPTH = `MSR_MEM_DEPTH,
   parameter AW = 5
) (
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_clear,
   input wire i_wr,
   input wire [15:0] i_data,
   output reg [AW-1:0] o_count_q,
   output wire [15:0] o_word0
);
   reg [15:0] mem_q [0:DEPTH-1];
   integer k;
   assign o_word0 = mem_q[0];
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count_q <= {AW{1'b0}};
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem_q[k] <= 16'h0000;
         end
      end else if (i_clear) begin
         o_count_q <= {AW{1'b0}};
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem_q[k] <= 16'h0000;
         end
      end else if (i_wr) begin
         if (i_data == `MSR_HDR_TX || i_data == `MSR_HDR_RX) begin
            mem_q[0] <= i_data;
            o_count_q <= {{(AW-1){1'b0}}, 1'b1};
         end else if (o_count_q < DEPTH[AW-1:0]) begin
            mem_q[o_count_q] <= i_data;
            o_count_q <= o_count_q + {{(AW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

//--- src/msr_regs.v
`timescale 1ns/1ps
`include "msr_defs.vh"
module msr_regs #(
   parameter PROG_CYC = `MSR_PROG_CYC,
   parameter MODE_CYC = `MSR_MODE_CYC
) (
   input wire i_mclk,
   input wire i_resetn,
   input wire i_rd,
   input wire i_wr,
   input wire [7:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_gen_reset,
   input wire i_ctl_reset,
   input wire i_ctl_irq_clr,
   input wire i_interrupt_pin_enable,
   input wire [4:0] i_irq_mask,
   input wire i_powersave,
   input wire i_tone_mode,
   input wire i_mode_change,
   input wire i_txdata_wr,
   input wire i_rx_sync,
   input wire [2:0] i_rx_fmt,
   input wire i_char_done,
   input wire [7:0] i_char_shift,
   input wire i_char_frame_err,
   input wire i_char_even_par,
   input wire i_demod,
   input wire i_energy,
   input wire i_pat_alt,
   input wire i_pat_zeros,
   input wire i_pat_ones,
   input wire i_tx_ready_evt,
   input wire i_tx_under_evt,
   input wire i_tone_a,
   input wire i_tone_b,
   input wire i_dtmf_valid,
   input wire [3:0] i_dtmf_code,
   output reg [15:0] o_rdata_q,
   output reg o_interrupt_line_low_active_q,
   output reg [4:0] o_prog_count_q
);
   reg rst_s1_q;
   reg rst_n_q;
   reg [15:0] st_q;
   reg [15:0] st_d;
   reg [15:0] prev_q;
   reg [7:0] rxbyte_q;
   reg prog_busy_q;
   reg [31:0] prog_cnt_q;
   reg [31:0] mode_cnt_q;
   reg ctl_reset_q;
   wire [7:0] packed_byte;
   wire [4:0] mem_count;
   wire [15:0] mem_word0;
   wire rd_status;
   wire rd_rxbyte;
   wire wr_prog;
   wire hold_mode;
   wire [15:0] rise;
   wire irq_set;

   // Masks a 9-bit event group (bits 13..5) with the five mask bits.
   function [15:0] gate;
      input [15:0] r;
      input [4:0] m;
      begin
         gate = 16'h0000;
         gate[`MSR_ST_PF] = r[`MSR_ST_PF] & m[`MSR_MSK_PF];
         gate[12] = r[12] & m[`MSR_MSK_TX];
         gate[11] = r[11] & m[`MSR_MSK_TX];
         gate[10] = r[10] & m[`MSR_MSK_EN];
         gate[9] = r[9] & m[`MSR_MSK_PAT];
         gate[8] = r[8] & m[`MSR_MSK_PAT];
         gate[7] = r[7] & m[`MSR_MSK_PAT];
         gate[6] = r[6] & m[`MSR_MSK_RX];
         gate[5] = r[5] & m[`MSR_MSK_RX];
      end
   endfunction

   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   assign rd_status = i_rd && (i_addr == `MSR_ADDR_STATUS);
   assign rd_rxbyte = i_rd && (i_addr == `MSR_ADDR_RXBYTE);
   assign wr_prog = i_wr && (i_addr == `MSR_ADDR_PROG);
   assign hold_mode = (mode_cnt_q != 32'h0);

   msr_rx_pack u_pack (
      .i_sync(i_rx_sync),
      .i_fmt(i_rx_fmt),
      .i_shift(i_char_shift),
      .o_byte(packed_byte)
   );

   msr_prog_mem #(
      .DEPTH(`MSR_MEM_DEPTH),
      .AW(5)
   ) u_mem (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n_q),
      .i_clear(i_powersave | i_gen_reset | i_ctl_reset),
      .i_wr(wr_prog & st_q[`MSR_ST_PF]),
      .i_data(i_wdata),
      .o_count_q(mem_count),
      .o_word0(mem_word0)
   );

   // Status value before the interrupt bit.
   always @* begin
      st_d = st_q;
      st_d[`MSR_ST_IRQ] = 1'b0;
      st_d[14] = 1'b0;
      if (!hold_mode) begin
         st_d[`MSR_ST_ENERGY] = i_energy;
         if (!i_tone_mode) begin
            st_d[`MSR_ST_ALT] = i_pat_alt;
            st_d[`MSR_ST_ZEROS] = i_pat_zeros;
            st_d[`MSR_ST_ONES] = i_pat_ones;
            if (i_tx_ready_evt) begin
               st_d[`MSR_ST_TXRDY] = 1'b1;
            end else if (i_txdata_wr) begin
               st_d[`MSR_ST_TXRDY] = 1'b0;
            end
            if (i_tx_under_evt) begin
               st_d[`MSR_ST_TXUND] = 1'b1;
            end else if (i_txdata_wr) begin
               st_d[`MSR_ST_TXUND] = 1'b0;
            end
            if (i_char_done) begin
               st_d[`MSR_ST_RXOVF] = st_q[`MSR_ST_RXRDY] & ~rd_rxbyte;
               st_d[`MSR_ST_RXRDY] = 1'b1;
               st_d[`MSR_ST_FRAME] = i_char_frame_err;
               st_d[`MSR_ST_PAR] = i_char_even_par;
            end else if (rd_rxbyte) begin
               st_d[`MSR_ST_RXRDY] = 1'b0;
               st_d[`MSR_ST_RXOVF] = 1'b0;
            end
            st_d[2] = 1'b0;
            st_d[1] = 1'b0;
            st_d[0] = i_demod;
         end else begin
            st_d[12] = 1'b0;
            st_d[11] = 1'b0;
            st_d[9] = 1'b0;
            st_d[8] = 1'b0;
            st_d[7] = i_tone_b;
            st_d[6] = i_tone_a;
            st_d[5] = i_dtmf_valid;
            st_d[4] = 1'b0;
            if (i_dtmf_valid) begin
               st_d[3:0] = i_dtmf_code;
            end
         end
      end
      st_d[`MSR_ST_PF] = ~prog_busy_q & ~ctl_reset_q & ~wr_prog;
   end

   assign rise = st_d & ~prev_q;
   assign irq_set = |gate(rise, i_irq_mask);

   always @(posedge i_mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= 16'h0000;
         prev_q <= 16'h0000;
         rxbyte_q <= 8'h00;
         prog_busy_q <= 1'b0;
         prog_cnt_q <= 32'h0;
         mode_cnt_q <= 32'h0;
         ctl_reset_q <= 1'b1;
         o_rdata_q <= 16'h0000;
         o_interrupt_line_low_active_q <= 1'b1;
         o_prog_count_q <= 5'h00;
      end else begin
         ctl_reset_q <= i_ctl_reset | i_gen_reset;
         o_prog_count_q <= mem_count;
         if (i_gen_reset || i_ctl_reset) begin
            st_q <= 16'h0000;
            prev_q <= 16'h0000;
            rxbyte_q <= 8'h00;
            prog_busy_q <= 1'b0;
            prog_cnt_q <= 32'h0;
            mode_cnt_q <= 32'h0;
            o_interrupt_line_low_active_q <= 1'b1;
         end else begin
            prev_q <= st_d;
            st_q[14:0] <= st_d[14:0];
            if (irq_set) begin
               st_q[`MSR_ST_IRQ] <= 1'b1;
            end else if (rd_status || i_ctl_irq_clr) begin
               st_q[`MSR_ST_IRQ] <= 1'b0;
            end
            o_interrupt_line_low_active_q <=
               ~((irq_set | (st_q[`MSR_ST_IRQ] & ~(rd_status | i_ctl_irq_clr)))
                 & i_interrupt_pin_enable);
            if (i_char_done && !i_tone_mode) begin
               rxbyte_q <= packed_byte;
            end
            if (i_mode_change) begin
               mode_cnt_q <= MODE_CYC;
            end else if (hold_mode) begin
               mode_cnt_q <= mode_cnt_q - 32'h1;
            end
            if (wr_prog && st_q[`MSR_ST_PF]) begin
               prog_busy_q <= 1'b1;
               prog_cnt_q <= PROG_CYC;
            end else if (prog_busy_q) begin
               if (prog_cnt_q <= 32'h1) begin
                  prog_busy_q <= 1'b0;
               end
               prog_cnt_q <= prog_cnt_q - 32'h1;
            end
         end
         if (rd_status) begin
            o_rdata_q <= st_q;
         end else if (rd_rxbyte) begin
            o_rdata_q <= {8'h00, rxbyte_q};
         end else if (i_rd) begin
            o_rdata_q <= 16'h0000;
         end
      end
   end
endmodule

//--- tb/msr_regs_properties.sv
`timescale 1ns/1ps
module msr_regs_chk (
   input wire i_mclk,
   input wire i_resetn,
   input wire i_rd,
   input wire i_wr,
   input wire [7:0] i_addr,
   input wire i_ctl_reset,
   input wire i_gen_reset,
   input wire i_interrupt_pin_enable,
   input wire i_tone_mode,
   input wire i_dtmf_valid,
   input wire [3:0] i_dtmf_code,
   input wire [15:0] o_rdata_q,
   input wire o_interrupt_line_low_active_q
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   wire st = i_rd && i_addr == 8'hE6;
   wire pin = o_interrupt_line_low_active_q;
   a_bit14_zero: assert property (st |=> !o_rdata_q[14])
      else $error("status bit 14 set");
   a_rxbyte_upper: assert property (i_rd && i_addr == 8'hE5 |=> o_rdata_q[15:8] == 8'h00)
      else $error("byte upper bits set");
   a_reset_clears: assert property (
      st && i_ctl_reset && $past(i_ctl_reset) |=> o_rdata_q == 16'h0000)
      else $error("status kept in reset");
   a_reset_no_irq: assert property (i_ctl_reset [*3] |-> pin)
      else $error("pin low in reset");
   a_pin_enable: assert property (!$past(i_interrupt_pin_enable) |-> pin)
      else $error("pin low while disabled");
   a_pin_follows_flag: assert property (
      st |=> $past(pin) == !(o_rdata_q[15] && $past(i_interrupt_pin_enable, 2)))
      else $error("pin high with flag");
   a_dtmf_code: assert property (
      st && $past(i_tone_mode) && $past(i_dtmf_valid) && !$past(i_ctl_reset)
      && !$past(i_gen_reset) |=> o_rdata_q[5:0] == {2'b10, $past(i_dtmf_code, 2)})
      else $error("tone code wrong");
   a_modem_zero: assert property (
      st && !i_tone_mode && !$past(i_tone_mode) && !$past(i_tone_mode, 2)
      |=> o_rdata_q[2:1] == 2'b00)
      else $error("modem bits 2 1 set");
   a_prog_clears_pf: assert property (i_wr && i_addr == 8'hE8 ##2 st |=> !o_rdata_q[13])
      else $error("flag kept after write");
   c_irq_read: cover property (st ##1 o_rdata_q[15]);
   c_pin_low: cover property (!pin);
   c_prog_write: cover property (i_wr && i_addr == 8'hE8);
endmodule

bind msr_regs msr_regs_chk i_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_rd(i_rd),
   .i_wr(i_wr), .i_addr(i_addr), .i_ctl_reset(i_ctl_reset), .i_tone_mode(i_tone_mode),
   .i_gen_reset(i_gen_reset), .i_interrupt_pin_enable(i_interrupt_pin_enable),
   .i_dtmf_valid(i_dtmf_valid),
   .i_dtmf_code(i_dtmf_code), .o_rdata_q(o_rdata_q),
   .o_interrupt_line_low_active_q(o_interrupt_line_low_active_q));

//--- tb/msr_host.sv
`timescale 1ns/1ps
module msr_host (
   input wire i_mclk,
   input wire [15:0] i_rdata,
   output reg o_rd,
   output reg o_wr,
   output reg [7:0] o_addr,
   output reg [15:0] o_wdata
);
   initial {o_rd, o_wr, o_addr, o_wdata} = 26'h0000000;
   // A released bus shows the inverse of its last address and data, with both strobes low.
   task acc(input w, input [7:0] a, input [15:0] d, output [15:0] q);
      begin
         @(negedge i_mclk);
         o_rd <= ~w;
         o_wr <= w;
         o_addr <= a;
         o_wdata <= d;
         @(negedge i_mclk);
         o_rd <= 1'b0;
         o_wr <= 1'b0;
         o_addr <= ~a;
         o_wdata <= ~d;
         q = i_rdata;
      end
   endtask
   task prog(input [15:0] d);
      reg [15:0] q;
      integer n;
      begin
         q = 16'h0000;
         n = 0;
         while (q[13] !== 1'b1 && n < 50) begin
            acc(1'b0, 8'hE6, 16'h0000, q);
            n = n + 1;
         end
         acc(1'b1, 8'hE8, d, q);
      end
   endtask
endmodule

//--- tb/test_msr_regs.sv
`timescale 1ns/1ps
module test_msr_regs;
   reg i_mclk = 1'b0, rstn = 1'b0, tone = 1'b0, syn = 1'b0, done = 1'b0, dem = 1'b0;
   reg ctl = 1'b0, pen = 1'b0, ps = 1'b0, dv = 1'b0, txw = 1'b0, fe = 1'b0, par = 1'b0;
   reg grst = 1'b0, iclr = 1'b0, mch = 1'b0, ta = 1'b0, tb = 1'b0;
   reg [2:0] fmt = 3'h0;
   reg [3:0] code = 4'h0;
   reg [4:0] msk = 5'h00;
   reg [5:0] pv = 6'h00;
   reg [7:0] sh = 8'h00;
   reg [15:0] s;
   wire rd, wr, pin;
   wire [7:0] ad;
   wire [15:0] rdat, wd;
   wire [4:0] cnt;
   integer n_errors = 0, num_checks = 0, cyc = 0, i, j;
   msr_host i_host (.i_mclk(i_mclk), .i_rdata(rdat), .o_rd(rd), .o_wr(wr), .o_addr(ad),
      .o_wdata(wd));
   msr_regs #(.PROG_CYC(5), .MODE_CYC(5)) i_msr_regs (.i_mclk(i_mclk), .i_resetn(rstn),
      .i_rd(rd), .i_wr(wr), .i_addr(ad), .i_wdata(wd), .i_gen_reset(grst), .i_ctl_reset(ctl),
      .i_ctl_irq_clr(iclr), .i_interrupt_pin_enable(pen), .i_irq_mask(msk), .i_powersave(ps),
      .i_tone_mode(tone), .i_mode_change(mch), .i_txdata_wr(txw), .i_rx_sync(syn),
      .i_rx_fmt(fmt), .i_char_done(done), .i_char_shift(sh), .i_char_frame_err(fe),
      .i_char_even_par(par), .i_demod(dem), .i_energy(pv[3]), .i_pat_alt(pv[2]),
      .i_pat_zeros(pv[1]), .i_pat_ones(pv[0]), .i_tx_ready_evt(pv[5]), .i_tx_under_evt(pv[4]),
      .i_tone_a(ta), .i_tone_b(tb), .i_dtmf_valid(dv), .i_dtmf_code(code),
      .o_rdata_q(rdat), .o_interrupt_line_low_active_q(pin), .o_prog_count_q(cnt));
   always #50 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end
   task cy(input integer n);
      repeat (n) @(negedge i_mclk);
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            n_errors = n_errors + 1;
         end
      end
   endtask
   task rc(input [7:0] a, input [15:0] e);
      begin
         i_host.acc(1'b0, a, 16'h0000, s);
         chk($sformatf("register %h", a), e, s);
      end
   endtask
   task ch(input [7:0] v);
      begin
         sh = v;
         done = 1'b1;
         cy(1);
         done = 1'b0;
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      cy(5);
      rstn = 1'b1;
      cy(4);
      rc(8'hE6, 16'h2000);
      {syn, dem, fe, par} = 4'hF;
      ch(8'hA5);
      rc(8'hE6, 16'h2059);
      ch(8'h5A);
      rc(8'hE6, 16'h2079);
      rc(8'hE5, 16'h005A);
      rc(8'hE6, 16'h2019);
      syn = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         fmt = {i[1:0], 1'b0};
         ch(8'hFF);
         rc(8'hE5, 16'h00FF >> (3 - i));
      end
      rc(8'hE7, 16'h0000);
      ctl = 1'b1;
      cy(2);
      rc(8'hE6, 16'h0000);
      ctl = 1'b0;
      cy(3);
      rc(8'hE6, 16'h2001);
      $display("end receive and reset");
      dem = 1'b0;
      pen = 1'b1;
      for (j = 0; j < 2; j = j + 1) begin
         for (i = 0; i < 6; i = i + 1) begin
            msk = ((i < 3) ? 5'h02 : (i == 3) ? 5'h04 : 5'h08) ^ {5{j[0]}};
            pv = 6'h01 << i;
            cy(4);
            chk("pin", {15'h0000, j[0]}, {15'h0000, pin});
            rc(8'hE6, 16'h2000 | (16'h0080 << i) | {~j[0], 15'h0000});
            pv = 6'h00;
            txw = 1'b1;
            cy(1);
            txw = 1'b0;
         end
         cy(2);
         chk("pin", 16'h0001, {15'h0000, pin});
      end
      $display("end events");
      pen = 1'b0;
      tone = 1'b1;
      msk = 5'h01;
      for (i = 0; i < 16; i = i + 1) begin
         code = i[3:0];
         dv = 1'b1;
         cy(3);
         rc(8'hE6, {4'hA, 8'h02, i[3:0]});
         dv = 1'b0;
         cy(1);
      end
      {ta, tb} = 2'b11;
      cy(3);
      chk("pin", 16'h0001, {15'h0000, pin});
      pen = 1'b1;
      cy(1);
      chk("pin", 16'h0000, {15'h0000, pin});
      iclr = 1'b1;
      cy(1);
      iclr = 1'b0;
      chk("pin", 16'h0001, {15'h0000, pin});
      rc(8'hE6, 16'h20CF);
      {tone, ta, tb, grst} = 4'h1;
      cy(1);
      grst = 1'b0;
      rc(8'hE6, 16'h0000);
      $display("end tone codes");
      msk = 5'h10;
      mch = 1'b1;
      cy(1);
      {mch, pv} = 7'h04;
      cy(2);
      rc(8'hE6, 16'h2000);
      cy(4);
      rc(8'hE6, 16'h2200);
      pv = 6'h00;
      $display("end mode hold");
      i_host.prog(16'h8001);
      i_host.prog(16'h1234);
      i_host.prog(16'h0042);
      i_host.acc(1'b1, 8'hE8, 16'h7777, s);
      cy(2);
      chk("count", 16'h0003, {11'h000, cnt});
      ps = 1'b1;
      cy(1);
      ps = 1'b0;
      cy(2);
      chk("count", 16'h0000, {11'h000, cnt});
      i_host.prog(16'h8000);
      cy(8);
      chk("count", 16'h0001, {11'h000, cnt});
      chk("pin", 16'h0000, {15'h0000, pin});
      rc(8'hE6, 16'hA000);
      $display("end programming");
      stop_test;
   end
endmodule
